// [shared/fpb_pkg.sv]
// Constants and types for the fault protection and blink indicator.
// Assumes a single 50 MHz core clock and a plain register port.
package fpb_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_FREQ_HZ / 1_000_000 * TICK_US;
  localparam int PERIOD_S = 3;
  localparam int PERIOD_TICKS = PERIOD_S * 1_000_000 / TICK_US;
  localparam int PULSE_MS = 200;
  localparam int PULSE_TICKS = PULSE_MS * 1000 / TICK_US;
  localparam int CNT_W = 16;
  localparam int HALF_W = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_FAULT = 8'h00;
  localparam logic [7:0] REG_IRQ_STS = 8'h04;
  localparam logic [7:0] REG_IRQ_CLR = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0c;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  localparam int FLD_WIND = 3;
  localparam int FLD_CODE = 4;
  localparam int FLD_LAMP = 7;

  // ****************************************
  // Blink counts per fault
  // ****************************************
  localparam logic [2:0] PULSES_NONE = 3'h0;
  localparam logic [2:0] PULSES_OC = 3'h1;
  localparam logic [2:0] PULSES_OV = 3'h2;
  localparam logic [2:0] PULSES_PH = 3'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic ph;
    logic ov;
    logic oc;
  } fpb_flt_t;

  typedef enum logic [0:0] {
    LMP_IDLE = 1'b0,
    LMP_RUN = 1'b1
  } fpb_lmp_t;
endpackage

// [logic/fpb_top.sv]
// Fault latch, winding release and fault lamp blink coder.
// Assumes detector inputs are asynchronous levels and the register
// master follows the one-cycle strobe protocol.
//
// Behaviour
// - Lamp pattern repeats every 3 seconds.
// - Pulse count per period names the fault.
// - Only one fault shown, by fixed priority.
// - Over-current latches, shows one pulse.
// - Over-voltage latches, shows two pulses.
// - Phase error latches, shows four pulses.
// - Any fault switches winding outputs off.
// - Faults clear only at power-on reset.
//
// Strobed register access and the register addresses were decided locally.
module fpb_top #(
  parameter int TICK_CYC = fpb_pkg::TICK_CYC,
  parameter int PERIOD_TICKS = fpb_pkg::PERIOD_TICKS,
  parameter int PULSE_TICKS = fpb_pkg::PULSE_TICKS
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // Register port
  input wire logic [fpb_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // Fault detectors
  input wire logic I_OC_DET,
  input wire logic I_OV_DET,
  input wire logic I_PH_DET,
  // Lamp, power stage and interrupt
  output logic O_LAMP,
  output logic O_WIND_EN,
  output logic O_IRQ
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int CW = fpb_pkg::CNT_W;
  localparam int HW = fpb_pkg::HALF_W;

  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0] flt_s1_ff;
  logic [2:0] flt_s2_ff;
  fpb_pkg::fpb_flt_t flt_ff;
  logic [2:0] flt_new;
  logic [TW-1:0] div_ff;
  logic tick_ff;
  fpb_pkg::fpb_lmp_t state_ff;
  logic [2:0] code_ff;
  logic [CW-1:0] ms_ff;
  logic [CW-1:0] sub_ff;
  logic [HW-1:0] half_ff;
  logic lamp_on;
  logic lamp_ff;
  logic wind_en_ff;
  logic [2:0] sts_ff;
  logic [2:0] nxt_sts;
  logic [2:0] en_ff;
  logic irq_ff;
  logic [31:0] rdata_ff;

  // Highest-priority fault as a blink count
  function automatic logic [2:0] sel_pulses(input fpb_pkg::fpb_flt_t f);
    logic [2:0] p;
    p = fpb_pkg::PULSES_NONE;
    if (f.oc) begin
      p = fpb_pkg::PULSES_OC;
    end else if (f.ov) begin
      p = fpb_pkg::PULSES_OV;
    end else if (f.ph) begin
      p = fpb_pkg::PULSES_PH;
    end
    return p;
  endfunction

  // ****************************************
  // Detector sync and fault latch
  // ****************************************

  // Two-stage synchroniser on detector levels
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      flt_s1_ff <= 3'h0;
      flt_s2_ff <= 3'h0;
    end else begin
      flt_s1_ff <= {I_PH_DET, I_OV_DET, I_OC_DET};
      flt_s2_ff <= flt_s1_ff;
    end
  end

  // Sticky latch, only reset clears it
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      flt_ff <= '0;
    end else begin
      flt_ff <= fpb_pkg::fpb_flt_t'(flt_ff | flt_s2_ff);
    end
  end

  // Newly tripped faults
  assign flt_new = flt_s2_ff & ~flt_ff;

  // Winding release on any fault
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wind_en_ff <= 1'b0;
    end else begin
      wind_en_ff <= ~(|flt_ff | |flt_s2_ff);
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************

  // Divider giving a one-cycle tick
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == TW'(TICK_CYC - 1)) begin
      div_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // ****************************************
  // Blink sequencer
  // ****************************************

  // Period, half-slot and code tracking
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_ff <= fpb_pkg::LMP_IDLE;
      code_ff <= fpb_pkg::PULSES_NONE;
      ms_ff <= '0;
      sub_ff <= '0;
      half_ff <= '0;
    end else begin
      case (state_ff)
        fpb_pkg::LMP_IDLE: begin
          if (|flt_ff) begin
            state_ff <= fpb_pkg::LMP_RUN;
            code_ff <= sel_pulses(flt_ff);
            ms_ff <= '0;
            sub_ff <= '0;
            half_ff <= '0;
          end
        end
        fpb_pkg::LMP_RUN: begin
          if (tick_ff) begin
            if (ms_ff == CW'(PERIOD_TICKS - 1)) begin
              ms_ff <= '0;
              sub_ff <= '0;
              half_ff <= '0;
              code_ff <= sel_pulses(flt_ff);
            end else begin
              ms_ff <= ms_ff + 1'b1;
              if (sub_ff == CW'(PULSE_TICKS - 1)) begin
                sub_ff <= '0;
                if (half_ff != {HW{1'b1}}) begin
                  half_ff <= half_ff + 1'b1;
                end
              end else begin
                sub_ff <= sub_ff + 1'b1;
              end
            end
          end
        end
        default: begin
          state_ff <= fpb_pkg::LMP_IDLE;
        end
      endcase
    end
  end

  // Lit on even half-slots below twice the count
  assign lamp_on = (state_ff == fpb_pkg::LMP_RUN) && !half_ff[0]
                   && (half_ff < {code_ff, 1'b0});

  // Registered lamp drive
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      lamp_ff <= 1'b0;
    end else begin
      lamp_ff <= lamp_on;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************

  // Sticky status, set beats clear
  always_comb begin
    nxt_sts = sts_ff;
    if (I_WR && (I_ADDR == fpb_pkg::REG_IRQ_CLR)) begin
      nxt_sts = sts_ff & ~I_WDATA[2:0];
    end
    nxt_sts = nxt_sts | flt_new;
  end

  // Status, enable and interrupt line
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sts_ff <= 3'h0;
      en_ff <= fpb_pkg::IRQ_EN_RST;
      irq_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      if (I_WR && (I_ADDR == fpb_pkg::REG_IRQ_EN)) begin
        en_ff <= I_WDATA[2:0];
      end
      irq_ff <= |(sts_ff & en_ff);
    end
  end

  // ****************************************
  // Register read
  // ****************************************

  // Read data valid one cycle after strobe
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= 32'h0;
      if (I_RD) begin
        case (I_ADDR)
          fpb_pkg::REG_FAULT: begin
            rdata_ff[2:0] <= flt_ff;
            rdata_ff[fpb_pkg::FLD_WIND] <= wind_en_ff;
            rdata_ff[fpb_pkg::FLD_CODE +: 3] <= code_ff;
            rdata_ff[fpb_pkg::FLD_LAMP] <= lamp_ff;
          end
          fpb_pkg::REG_IRQ_STS: begin
            rdata_ff[2:0] <= sts_ff;
          end
          fpb_pkg::REG_IRQ_EN: begin
            rdata_ff[2:0] <= en_ff;
          end
          default: begin
            rdata_ff <= 32'h0;
          end
        endcase
      end
    end
  end

  // Output drive
  assign O_RDATA = rdata_ff;
  assign O_LAMP = lamp_ff;
  assign O_WIND_EN = wind_en_ff;
  assign O_IRQ = irq_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  // Latched fault keeps windings off
  property p_wind_off;
    (|flt_ff) |-> !O_WIND_EN;
  endproperty
  a_wind_off: assert property (p_wind_off)
    else $error("windings enabled during fault");

  // No latched bit ever drops
  property p_latch_hold;
    ($past(flt_ff) & ~flt_ff) == 3'h0;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("fault latch cleared");

  // Over-current latches, code one
  property p_oc;
    flt_s2_ff[0] |=> flt_ff.oc && (sel_pulses(flt_ff) == 3'h1);
  endproperty
  a_oc: assert property (p_oc)
    else $error("over-current not latched");

  // Over-voltage latches, code two
  property p_ov;
    (flt_s2_ff[1] && !flt_ff.oc && !flt_s2_ff[0]) |=> flt_ff.ov && (sel_pulses(flt_ff) == 3'h2);
  endproperty
  a_ov: assert property (p_ov)
    else $error("over-voltage not latched");

  // Phase error alone gives code four
  property p_ph;
    (flt_s2_ff == 3'h4 && flt_ff == 3'h0) |=> ##1 (code_ff == 3'h4);
  endproperty
  a_ph: assert property (p_ph)
    else $error("phase error code wrong");

  // Over-current wins at period start
  property p_prio;
    (tick_ff && state_ff == fpb_pkg::LMP_RUN && ms_ff == CW'(PERIOD_TICKS - 1) && flt_ff.oc)
      |=> code_ff == 3'h1;
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority not honoured");

  // Dark without a fault
  property p_dark_idle;
    (state_ff == fpb_pkg::LMP_IDLE) |=> !O_LAMP;
  endproperty
  a_dark_idle: assert property (p_dark_idle)
    else $error("lamp lit with no fault");

  // Period wraps at its last tick
  property p_wrap;
    (tick_ff && state_ff == fpb_pkg::LMP_RUN && ms_ff == CW'(PERIOD_TICKS - 1))
      |=> (ms_ff == 0 && half_ff == 0);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("period did not wrap");

  // Lamp lit only inside coded pulses
  property p_count;
    O_LAMP |-> ($past(half_ff) < {$past(code_ff), 1'b0}) && !$past(half_ff[0]);
  endproperty
  a_count: assert property (p_count)
    else $error("lamp lit outside pulse slot");

  // Pulse start lights lamp next cycle
  property p_pulse_on;
    (state_ff == fpb_pkg::LMP_RUN && half_ff == 0 && code_ff != 0) |=> O_LAMP;
  endproperty
  a_pulse_on: assert property (p_pulse_on)
    else $error("first pulse missing");

  // Enabled status raises interrupt
  property p_irq;
    (|(sts_ff & en_ff)) |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

endmodule

// [dv/fpb_lamp_mon.sv]
// Lamp and power stage model: counts lamp pulses and timing.
// Assumes the lamp and winding enable are registered levels.
module fpb_lamp_mon (
  // Clock
  input wire logic i_clk,
  // Device outputs
  input wire logic i_lamp,
  input wire logic i_wind_en,
  // Observations
  output int o_cyc,
  output int o_rises,
  output int o_last_rise,
  output int o_last_on,
  output logic o_shaft_free
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lamp_d = 1'b0;
  int on_cnt = 0;
  // Unpowered winding leaves shaft free
  assign o_shaft_free = !i_wind_en;
  // Pulse edges, on length and period timing
  always @(posedge i_clk) begin
    o_cyc <= o_cyc + 1;
    lamp_d <= i_lamp;
    if (i_lamp && !lamp_d) begin
      o_rises <= o_rises + 1;
      o_last_rise <= o_cyc;
    end
    on_cnt <= i_lamp ? on_cnt + 1 : 0;
    if (!i_lamp && lamp_d) o_last_on <= on_cnt;
  end
endmodule

// [dv/test_fault_protection_blink_indicator.sv]
// Testbench for the fault latch, winding release and lamp coder.
// Assumes short timing parameters: 4-cycle tick, 40-tick period.
module test_fault_protection_blink_indicator;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TCK = 4;
  localparam int PER = 40;
  localparam int PUL = 3;
  localparam int PER_CYC = TCK * PER;
  localparam int PUL_CYC = TCK * PUL;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0] det = 3'h0;
  logic lamp, wind_en, irq, shaft_free;
  int cyc, rises, last_rise, last_on;
  int fails = 0;
  int n_tests = 0;
  logic [31:0] d;
  // ****************************************
  // Clock, design and partner
  // ****************************************
  always #10 clk = ~clk;
  fpb_top #(.TICK_CYC(TCK), .PERIOD_TICKS(PER), .PULSE_TICKS(PUL)) dut (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_OC_DET(det[0]), .I_OV_DET(det[1]),
    .I_PH_DET(det[2]), .O_LAMP(lamp), .O_WIND_EN(wind_en), .O_IRQ(irq));
  fpb_lamp_mon mon (.i_clk(clk), .i_lamp(lamp), .i_wind_en(wind_en), .o_cyc(cyc),
    .o_rises(rises), .o_last_rise(last_rise), .o_last_on(last_on), .o_shaft_free(shaft_free));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    det <= 3'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wait_cyc(2);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_idle();
    do_reset();
    chk("wind_en idle", 32'h1, {31'h0, wind_en});
    wait_cyc(PER_CYC);
    chk("lamp dark", 32'h0, {31'h0, lamp});
    reg_rd(fpb_pkg::REG_FAULT, d);
    chk("fault reg idle", 32'h8, d);
    $display("test idle done");
  endtask
  task automatic t_fault(input logic [2:0] f, input int n);
    int r0, t0, k;
    do_reset();
    @(posedge clk);
    det <= f;
    repeat (5) @(posedge clk);
    det <= 3'h0;
    #1;
    chk("wind_en off", 32'h0, {31'h0, wind_en});
    chk("shaft free", 32'h1, {31'h0, shaft_free});
    r0 = rises;
    k = 0;
    while (rises == r0 && k < 400) begin
      wait_cyc(1);
      k++;
    end
    t0 = last_rise;
    // First period starts off the tick grid, so measure the second one
    while (cyc < t0 + PER_CYC - 2 * TCK) wait_cyc(1);
    r0 = rises;
    k = 0;
    while (rises == r0 && k < 400) begin
      wait_cyc(1);
      k++;
    end
    t0 = last_rise;
    while (cyc < t0 + PER_CYC + 3) wait_cyc(1);
    chk("pulses per period", n + 1, rises - r0);
    chk("period", t0 + PER_CYC, last_rise);
    chk("pulse on length", PUL_CYC, last_on);
    reg_rd(fpb_pkg::REG_FAULT, d);
    chk("latched flags", {29'h0, f}, {29'h0, d[2:0]});
    chk("shown count", n, {29'h0, d[6:4]});
    chk("wind_en held", 32'h0, {31'h0, wind_en});
    $display("test fault %b done", f);
  endtask
  task automatic t_irq();
    do_reset();
    reg_rd(fpb_pkg::REG_IRQ_EN, d);
    chk("irq_en reset", 32'h0, d);
    @(posedge clk);
    det <= 3'h2;
    wait_cyc(6);
    chk("irq masked", 32'h0, {31'h0, irq});
    reg_rd(fpb_pkg::REG_IRQ_STS, d);
    chk("irq status", 32'h2, d);
    reg_wr(fpb_pkg::REG_IRQ_EN, 32'h2);
    wait_cyc(2);
    chk("irq raised", 32'h1, {31'h0, irq});
    @(posedge clk);
    det <= 3'h0;
    reg_wr(fpb_pkg::REG_IRQ_CLR, 32'h2);
    reg_wr(fpb_pkg::REG_FAULT, 32'h0);
    wait_cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    reg_rd(fpb_pkg::REG_IRQ_STS, d);
    chk("status cleared", 32'h0, d);
    reg_rd(fpb_pkg::REG_IRQ_CLR, d);
    chk("clear reads zero", 32'h0, d);
    reg_rd(8'h10, d);
    chk("unmapped read", 32'h0, d);
    reg_rd(fpb_pkg::REG_FAULT, d);
    chk("fault survives writes", 32'h2, {29'h0, d[2:0]});
    chk("wind_en stays off", 32'h0, {31'h0, wind_en});
    $display("test irq done");
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  initial begin
    t_idle();
    t_fault(3'h1, 1);
    t_fault(3'h2, 2);
    t_fault(3'h4, 4);
    t_fault(3'h7, 1);
    t_fault(3'h6, 2);
    t_fault(3'h5, 1);
    t_irq();
    stop_test();
  end
endmodule
